/* verilog/elp_pkg.sv */
// Contract
// [R1] periodic current pointer holds address bits 31:4
// [R2] periodic pointer names list head this frame
// [R3] periodic pointer updates after each periodic descriptor
// [R4] reads of periodic pointer return live value
// [R5] control head pointer holds address bits 31:4
// [R6] control traversal starts at head pointer
// [R7] head pointer loaded from shared area at init
// [R8] control current advances after serving descriptor
// [R9] each frame resumes where control list stopped
// [R10] list end: filled flag set copies head, clears
// [R11] driver writes current only while list disabled
// [R12] control current pointer starts at zero
// [R13] registers at 1Ch, 20h, 24h, reset zero
// [R14] low bits 3:0 always read zero
`default_nettype none
package elp_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0]  PERIODIC_CURRENT_OFS = 8'h1C; // periodic current pointer
  localparam logic [7:0]  CONTROL_HEAD_OFS     = 8'h20; // control list head
  localparam logic [7:0]  CONTROL_CURRENT_OFS  = 8'h24; // control list current
  // ----------------------------------------
  // field layout and reset
  // ----------------------------------------
  localparam int          ADDR_LSB             = 4;     // pointer field low bit
  localparam int          ADDR_W               = 28;    // pointer field width
  localparam logic [27:0] POINTER_RESET        = 28'h0000000;
  localparam logic [27:0] END_OF_LIST          = 28'h0000000; // zero marks list end
  localparam int          CONTROL_LIST_FILLED_BIT = 1;  // bit in command status
  localparam int          CONTROL_LIST_ENABLE_BIT = 4;  // bit in control register
  localparam int          NUM_POINTERS         = 3;
  // ----------------------------------------
  // pointer selector
  // ----------------------------------------
  typedef enum logic [1:0] {
    ELP_SEL_PERIODIC,
    ELP_SEL_HEAD,
    ELP_SEL_CURRENT,
    ELP_SEL_NONE
  } elp_sel_e;
endpackage : elp_pkg
`default_nettype wire

/* verilog/elp_pointer_reg.sv */
`timescale 1ns/1ps
`default_nettype none
// one pointer register; field kept 28 bits so low bits cannot exist
module elp_pointer_reg (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        load,
  input  wire logic [27:0] load_value,
  output var  logic [27:0] value
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      value <= elp_pkg::POINTER_RESET; // R13
    end else if (load) begin
      value <= load_value;
    end
  end
endmodule : elp_pointer_reg
`default_nettype wire

/* verilog/elp_list_pointers.sv */
`timescale 1ns/1ps
`default_nettype none
module elp_list_pointers (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // register read/write port of the controller register space
  input  wire logic        reg_read,
  input  wire logic        reg_write,
  input  wire logic [7:0]  reg_offset,
  input  wire logic [31:0] reg_write_data,
  output var  logic [31:0] reg_read_data,
  output var  logic        reg_hit,
  // control register, list enable bit
  input  wire logic [31:0] control_register,
  // core side: initialization load from shared area
  input  wire logic        init_load_head,
  input  wire logic [31:0] shared_area_head,
  // core side: periodic walk
  input  wire logic        frame_start,
  input  wire logic        periodic_done,
  input  wire logic [31:0] periodic_next,
  // core side: control walk
  input  wire logic        control_done,
  input  wire logic [31:0] control_next,
  input  wire logic        control_list_end,
  input  wire logic        control_list_filled,
  output logic             clear_control_list_filled,
  output logic [31:0]      control_fetch_address,
  output logic [31:0]      periodic_fetch_address
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  // offset to pointer select, used by read and write paths
  function automatic elp_pkg::elp_sel_e decode_offset(input logic [7:0] ofs);
    case (ofs)
      elp_pkg::PERIODIC_CURRENT_OFS: decode_offset = elp_pkg::ELP_SEL_PERIODIC;
      elp_pkg::CONTROL_HEAD_OFS:     decode_offset = elp_pkg::ELP_SEL_HEAD;
      elp_pkg::CONTROL_CURRENT_OFS:  decode_offset = elp_pkg::ELP_SEL_CURRENT;
      default:                       decode_offset = elp_pkg::ELP_SEL_NONE;
    endcase
  endfunction : decode_offset

  elp_pkg::elp_sel_e rd_sel;          // read target
  elp_pkg::elp_sel_e wr_sel;          // write target
  logic              list_enabled;    // control list enable
  logic [27:0]       periodic_current_address;
  logic [27:0]       control_head_address;
  logic [27:0]       control_current_address;
  logic              load_periodic;
  logic              load_head;
  logic              load_current;
  logic [27:0]       next_periodic;
  logic [27:0]       next_head;
  logic [27:0]       next_current;

  assign rd_sel       = decode_offset(reg_offset);
  assign wr_sel       = decode_offset(reg_offset);
  assign list_enabled = control_register[elp_pkg::CONTROL_LIST_ENABLE_BIT];

  // ----------------------------------------
  // periodic current pointer
  // ----------------------------------------
  // the core updates after each periodic descriptor; software cannot write
  always_comb begin
    load_periodic = periodic_done;                                        // R3
    next_periodic = periodic_next[31:elp_pkg::ADDR_LSB];                  // R1
  end

  // ----------------------------------------
  // control head pointer
  // ----------------------------------------
  // loaded from the shared area at init; read-only to software
  always_comb begin
    load_head = init_load_head;                                           // R7
    next_head = shared_area_head[31:elp_pkg::ADDR_LSB];                   // R5
  end

  // ----------------------------------------
  // control current pointer
  // ----------------------------------------
  // priority: list end (reload if filled), then advance, then driver write
  always_comb begin
    load_current              = 1'b0;
    next_current              = control_current_address;
    clear_control_list_filled = 1'b0;
    if (control_list_end) begin
      if (control_list_filled) begin                                      // R10
        load_current              = 1'b1;
        next_current              = control_head_address;                 // R6
        clear_control_list_filled = 1'b1;                                 // R10
      end
    end else if (control_done) begin
      load_current = 1'b1;                                                // R8
      next_current = control_next[31:elp_pkg::ADDR_LSB];
    end else if (reg_write && wr_sel == elp_pkg::ELP_SEL_CURRENT && !list_enabled) begin
      // writes while the list runs are dropped, avoiding a torn walk
      load_current = 1'b1;                                                // R11
      next_current = reg_write_data[31:elp_pkg::ADDR_LSB];
    end
  end

  // ----------------------------------------
  // storage, one instance per pointer
  // ----------------------------------------
  elp_pointer_reg u_periodic (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .load       (load_periodic),
    .load_value (next_periodic),
    .value      (periodic_current_address)
  );
  elp_pointer_reg u_head (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .load       (load_head),
    .load_value (next_head),
    .value      (control_head_address)
  );
  // current starts at zero: end of list until reloaded
  elp_pointer_reg u_current (                                             // R12
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .load       (load_current),
    .load_value (next_current),
    .value      (control_current_address)
  );

  // ----------------------------------------
  // fetch addresses toward the core
  // ----------------------------------------
  // current pointer persists across frames so the walk resumes there
  assign control_fetch_address  = {control_current_address, 4'h0};      // R9
  assign periodic_fetch_address = {periodic_current_address, 4'h0};     // R2

  // ----------------------------------------
  // read data, registered
  // ----------------------------------------
  // low nibble forced to zero for 16-byte alignment
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_read_data <= 32'h00000000;
      reg_hit       <= 1'b0;
    end else begin
      reg_hit <= reg_read && rd_sel != elp_pkg::ELP_SEL_NONE;             // R13
      if (reg_read) begin
        case (rd_sel)
          elp_pkg::ELP_SEL_PERIODIC: reg_read_data <= {periodic_current_address, 4'h0}; // R4 R14
          elp_pkg::ELP_SEL_HEAD:     reg_read_data <= {control_head_address, 4'h0};     // R14
          elp_pkg::ELP_SEL_CURRENT:  reg_read_data <= {control_current_address, 4'h0};  // R14
          default:                   reg_read_data <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // helper: a read of one of the three mapped offsets, spelled out by address
  logic              mapped_read;
  assign mapped_read = reg_read && (reg_offset == elp_pkg::PERIODIC_CURRENT_OFS ||
                                    reg_offset == elp_pkg::CONTROL_HEAD_OFS ||
                                    reg_offset == elp_pkg::CONTROL_CURRENT_OFS);

  // a read of the periodic pointer returns its value at the read edge
  property read_live_p;
    @(posedge clk_sys) disable iff (!reset_n)
      reg_read && rd_sel == elp_pkg::ELP_SEL_PERIODIC |=> reg_read_data == {$past(periodic_current_address), 4'h0};
  endproperty
  periodic_read_a: assert property (read_live_p) // R4
    else $error("periodic read not live");

  // reserved nibble never shows, whatever the core handed in
  low_bits_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R14
    reg_read_data[3:0] == 4'h0)
    else $error("reserved bits not zero");

  // mapped offsets answer with a hit, anything else never does
  read_hit_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R13
    mapped_read |=> reg_hit)
    else $error("mapped read without hit");

  no_hit_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R13
    !mapped_read |=> !reg_hit)
    else $error("hit without mapped read");

  periodic_update_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R3
    periodic_done |=> periodic_current_address == $past(periodic_next[31:elp_pkg::ADDR_LSB]))
    else $error("periodic not updated");

  // no other path moves the periodic pointer; software cannot write it
  periodic_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R3
    !periodic_done |=> $stable(periodic_current_address))
    else $error("periodic moved without update");

  head_load_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R7
    init_load_head |=> control_head_address == $past(shared_area_head[31:elp_pkg::ADDR_LSB]))
    else $error("head not loaded");

  // head is read-only to software; only the init load moves it
  head_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R7
    !init_load_head |=> $stable(control_head_address))
    else $error("head moved without load");

  sequence end_filled_s;
    control_list_end && control_list_filled;
  endsequence
  reload_head_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R10
    end_filled_s |=> control_current_address == $past(control_head_address))
    else $error("no reload");

  clear_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R10
    end_filled_s |-> clear_control_list_filled)
    else $error("flag not cleared");

  // a stray clear would drop work the driver queued
  flag_quiet_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R10
    !(control_list_end && control_list_filled) |-> !clear_control_list_filled)
    else $error("flag cleared without reload");

  end_unfilled_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R10
    control_list_end && !control_list_filled |=> $stable(control_current_address))
    else $error("changed at end");

  advance_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R8
    !control_list_end && control_done |=> control_current_address == $past(control_next[31:elp_pkg::ADDR_LSB]))
    else $error("no advance");

  locked_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R11
    list_enabled && !control_list_end && !control_done |=> $stable(control_current_address))
    else $error("write while enabled");

  // a driver write lands only with the list stopped and no list-end or advance strobe
  sequence free_write_s;
    reg_write && reg_offset == elp_pkg::CONTROL_CURRENT_OFS && !list_enabled &&
    !control_list_end && !control_done;
  endsequence
  write_taken_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R11
    free_write_s |=> control_current_address == $past(reg_write_data[31:elp_pkg::ADDR_LSB]))
    else $error("driver write lost");

  // a frame boundary alone never moves the current pointer, so the walk resumes there
  frame_resume_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // R9
    frame_start && !control_list_end && !control_done && !reg_write |=> $stable(control_current_address))
    else $error("pointer moved at frame start");
endmodule : elp_list_pointers
`default_nettype wire

/* bench/elp_list_pointers_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module elp_list_pointers_tb_top;
  // ----------------------------------------
  // stimulus and observed nets
  // ----------------------------------------
  logic        clk_sys = 1'b0;       // 125 MHz system clock
  logic        reset_n = 1'b0;       // held low at start
  logic        reg_read = 1'b0, reg_write = 1'b0;
  logic [7:0]  reg_offset = 8'h00;
  logic [31:0] reg_write_data = 32'h00000000, control_register = 32'h00000000;
  logic        init_load_head = 1'b0, frame_start = 1'b0, periodic_done = 1'b0;
  logic        control_done = 1'b0, control_list_end = 1'b0, control_list_filled = 1'b0;
  logic [31:0] shared_area_head = 32'h00000000, periodic_next = 32'h00000000, control_next = 32'h00000000;
  logic [31:0] reg_read_data, control_fetch_address, periodic_fetch_address;
  logic        reg_hit, clear_control_list_filled;
  int          failures = 0;         // mismatches seen
  int          cmp_count = 0;        // comparisons made
  always #4 clk_sys = ~clk_sys;
  elp_list_pointers elp_list_pointers_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_read(reg_read), .reg_write(reg_write),
    .reg_offset(reg_offset), .reg_write_data(reg_write_data), .reg_read_data(reg_read_data),
    .reg_hit(reg_hit), .control_register(control_register), .init_load_head(init_load_head),
    .shared_area_head(shared_area_head), .frame_start(frame_start), .periodic_done(periodic_done),
    .periodic_next(periodic_next), .control_done(control_done), .control_next(control_next),
    .control_list_end(control_list_end), .control_list_filled(control_list_filled),
    .clear_control_list_filled(clear_control_list_filled),
    .control_fetch_address(control_fetch_address), .periodic_fetch_address(periodic_fetch_address)
  );
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // compare, four-state so unknowns never match
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one-cycle read pulse; data lands at the taking edge
  task automatic rd(input logic [7:0] ofs, input logic [31:0] exp, input logic exp_hit);
    @(negedge clk_sys);
    reg_read   = 1'b1;
    reg_offset = ofs;
    @(negedge clk_sys);
    reg_read = 1'b0;
    check("read data", reg_read_data, exp);
    check("read hit", {31'h0, reg_hit}, {31'h0, exp_hit});
  endtask : rd
  task automatic wr(input logic [7:0] ofs, input logic [31:0] data);
    @(negedge clk_sys);
    reg_write      = 1'b1;
    reg_offset     = ofs;
    reg_write_data = data;
    @(negedge clk_sys);
    reg_write = 1'b0;
  endtask : wr
  // one cycle of core strobes; clear flag must follow end and filled at once
  task automatic core_step(input logic ih, input logic pd, input logic cd, input logic le, input logic lf);
    @(negedge clk_sys);
    {init_load_head, periodic_done, control_done, control_list_end, control_list_filled} = {ih, pd, cd, le, lf};
    #1 check("clear flag", {31'h0, clear_control_list_filled}, {31'h0, le & lf});
    @(negedge clk_sys);
    {init_load_head, periodic_done, control_done, control_list_end, control_list_filled} = 5'h00;
  endtask : core_step
  // ----------------------------------------
  // watchdog: whole sequence needs well under 200 cycles
  // ----------------------------------------
  initial begin
    #20000;
    failures++;
    end_of_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) reset_n = 1'b1;
    rd(elp_pkg::PERIODIC_CURRENT_OFS, 32'h00000000, 1'b1);
    rd(elp_pkg::CONTROL_HEAD_OFS, 32'h00000000, 1'b1);
    rd(elp_pkg::CONTROL_CURRENT_OFS, 32'h00000000, 1'b1);
    rd(8'h28, 32'h00000000, 1'b0);
    // head from shared area, low nibble dropped
    shared_area_head = 32'h1234567F;
    core_step(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    rd(elp_pkg::CONTROL_HEAD_OFS, 32'h12345670, 1'b1);
    check("control fetch", control_fetch_address, 32'h00000000);
    // periodic walk updates live pointer
    periodic_next = 32'hABCDEF0F;
    core_step(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    rd(elp_pkg::PERIODIC_CURRENT_OFS, 32'hABCDEF00, 1'b1);
    check("periodic fetch", periodic_fetch_address, 32'hABCDEF00);
    // driver write taken only with list disabled
    wr(elp_pkg::CONTROL_CURRENT_OFS, 32'h1111111F);
    rd(elp_pkg::CONTROL_CURRENT_OFS, 32'h11111110, 1'b1);
    control_register = 32'h00000010;
    wr(elp_pkg::CONTROL_CURRENT_OFS, 32'h22222220);
    rd(elp_pkg::CONTROL_CURRENT_OFS, 32'h11111110, 1'b1);
    wr(elp_pkg::CONTROL_HEAD_OFS, 32'h55555550);
    rd(elp_pkg::CONTROL_HEAD_OFS, 32'h12345670, 1'b1);
    // advance after serving, held across frame boundary
    control_next = 32'h33333335;
    core_step(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    @(negedge clk_sys) frame_start = 1'b1;
    @(negedge clk_sys) frame_start = 1'b0;
    check("control fetch", control_fetch_address, 32'h33333330);
    // list end: no reload without flag, reload from head with it
    core_step(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    rd(elp_pkg::CONTROL_CURRENT_OFS, 32'h33333330, 1'b1);
    core_step(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(elp_pkg::CONTROL_CURRENT_OFS, 32'h12345670, 1'b1);
    check("control fetch", control_fetch_address, 32'h12345670);
    // same-cycle contention on current: reload, then advance, then driver write
    control_register = 32'h00000000;
    control_next     = 32'h44444440;
    fork
      wr(elp_pkg::CONTROL_CURRENT_OFS, 32'h66666660);
      core_step(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    join
    rd(elp_pkg::CONTROL_CURRENT_OFS, 32'h44444440, 1'b1);
    // end without flag ignores a same-cycle advance
    control_next = 32'h88888880;
    core_step(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    rd(elp_pkg::CONTROL_CURRENT_OFS, 32'h44444440, 1'b1);
    fork
      wr(elp_pkg::CONTROL_CURRENT_OFS, 32'h77777770);
      core_step(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    join
    rd(elp_pkg::CONTROL_CURRENT_OFS, 32'h12345670, 1'b1);
    // mid-run reset returns every pointer to zero
    @(negedge clk_sys) reset_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    check("periodic fetch", periodic_fetch_address, 32'h00000000);
    check("control fetch", control_fetch_address, 32'h00000000);
    rd(elp_pkg::PERIODIC_CURRENT_OFS, 32'h00000000, 1'b1);
    rd(elp_pkg::CONTROL_HEAD_OFS, 32'h00000000, 1'b1);
    rd(elp_pkg::CONTROL_CURRENT_OFS, 32'h00000000, 1'b1);
    end_of_test();
  end
endmodule : elp_list_pointers_tb_top
`default_nettype wire
